/* File: verilog/cct_defs.svh */
// Constants for the calendar timer unit
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH
`define CCT_CNT_W      32
`define CCT_PSEL_W     5
`define CCT_SEC_LSB    0
`define CCT_MIN_LSB    6
`define CCT_HOUR_LSB   12
`define CCT_DAY_LSB    17
`define CCT_MON_LSB    22
`define CCT_YEAR_LSB   26
`define CCT_SEC_MAX    6'h3b
`define CCT_MIN_MAX    6'h3b
`define CCT_HOUR_MAX   5'h17
`define CCT_DAY_FIRST  5'h01
`define CCT_MON_FIRST  4'h1
`define CCT_MON_LAST   4'hc
`define CCT_MON_FEB    4'h2
`define CCT_DAYS_FEB   5'h1c
`define CCT_DAYS_LEAP  5'h1d
`define CCT_DAYS_SHORT 5'h1e
`define CCT_DAYS_LONG  5'h1f
`define CCT_LEAP_BITS  2'h0
`define CCT_RST_VALUE  32'h0000_0000
`define CCT_CAL_RST    32'h0042_0000
`define CCT_IRQ_OVF    0
`define CCT_IRQ_PER0   1
`define CCT_IRQ_PER1   2
`define CCT_IRQ_MATCH0 3
`define CCT_IRQ_MATCH1 4
`define CCT_IRQ_CLKRDY 5
`define CCT_IRQ_READY  6
`define CCT_IRQ_N      7
`endif

/* File: verilog/cct_pkg.sv */
// Types shared by the calendar timer unit
package cct_pkg;
  typedef struct packed {
    logic [5:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } cct_cal_s;
  typedef logic [6:0] cct_irq_t;
endpackage

/* File: verilog/cct_calendar_timer_unit.sv */
// Calendar timer unit: counter, calendar, match and interrupt logic
// Contract
// - Calendar mode selected when date_mode bit is one, else binary count.
// - Software can read and write current date and time in calendar mode.
// - Time kept as seconds, minutes and 24-hour hours fields.
// - Day of month starts at 1; month numbered from January as 1.
// - Year is a 6-bit offset from a software-chosen leap year.
// - February rollover treats year offsets divisible by four as leap.
// - Events and interrupts behave the same in both counting modes.
// - Five request lines: overflow, periodic, match, clock-ready, ready.
// - Overflow on wrap, and on match 0 when clear-on-match is set.
// - Clock-ready request on falling edge of clock_sync_pending.
// - Ready request on falling edge of the busy status bit.
// - Requests gated by mask; set and clear by write-one pulses.
// - Request holds until software clears its status bit or its mask bit.
// - Requests are levels usable for wakeup while clock runs.
// - Periodic request on each rising edge of selected prescaler tap.
`include "cct_defs.svh"
module cct_calendar_timer_unit
  import cct_pkg::*;
(
  // Clock and reset
  input  wire logic                   ref_clk_in,
  input  wire logic                   rst_in,
  // Control
  input  wire logic                   run_in,
  input  wire logic                   date_mode_bit_in,
  input  wire logic                   clear_on_match_in,
  input  wire logic [`CCT_PSEL_W-1:0] tick_sel_in,
  input  wire logic [`CCT_PSEL_W-1:0] per0_sel_in,
  input  wire logic [`CCT_PSEL_W-1:0] per1_sel_in,
  // Value write port
  input  wire logic                   value_wr_in,
  input  wire logic [`CCT_CNT_W-1:0]  value_wdata_in,
  input  wire logic [`CCT_CNT_W-1:0]  match_value_0_in,
  input  wire logic [`CCT_CNT_W-1:0]  match_value_1_in,
  // Synchroniser status from the clock domain glue
  input  wire logic                   clock_sync_pending_in,
  input  wire logic                   busy_in,
  // Mask and status write-one strobes
  input  wire cct_irq_t               mask_set_in,
  input  wire cct_irq_t               mask_clear_in,
  input  wire cct_irq_t               status_clear_in,
  // Status and value
  output logic [`CCT_CNT_W-1:0]       value_out,
  output cct_irq_t                    status_out,
  output cct_irq_t                    irq_mask_out,
  // Interrupt request lines
  output logic                        overflow_irq_out,
  output logic                        periodic_irq_out,
  output logic                        match_irq_out,
  output logic                        clock_sync_done_irq_out,
  output logic                        ready_irq_out
);
  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  logic [`CCT_CNT_W-1:0] psc_q;
  logic                  tick_tap_q;
  logic                  per0_tap_q;
  logic                  per1_tap_q;
  logic [`CCT_CNT_W-1:0] psc_d;
  wire                   tick_tap = psc_d[tick_sel_in];
  wire                   per0_tap = psc_d[per0_sel_in];
  wire                   per1_tap = psc_d[per1_sel_in];
  wire                   tick     = tick_tap & ~tick_tap_q;
  wire                   per0_ev  = per0_tap & ~per0_tap_q;
  wire                   per1_ev  = per1_tap & ~per1_tap_q;

  assign psc_d = run_in ? psc_q + 32'h1 : psc_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      psc_q      <= `CCT_RST_VALUE;
      tick_tap_q <= 1'b0;
      per0_tap_q <= 1'b0;
      per1_tap_q <= 1'b0;
    end
    else
    begin
      psc_q      <= psc_d;
      tick_tap_q <= tick_tap;
      per0_tap_q <= per0_tap;
      per1_tap_q <= per1_tap;
    end
  end

  // ----------------------------------------------------------------
  // Calendar next value
  // ----------------------------------------------------------------
  logic [`CCT_CNT_W-1:0] cnt_q;
  cct_cal_s              cal;
  cct_cal_s              cal_inc;
  logic [4:0]            days_in_month;
  logic                  leap;

  assign cal  = cnt_q;
  // Year offset counts from a leap year, so low two bits zero means leap
  assign leap = (cal.year[1:0] == `CCT_LEAP_BITS);

  always_comb
  begin
    days_in_month = `CCT_DAYS_LONG;
    case (cal.month)
      `CCT_MON_FEB: days_in_month = leap ? `CCT_DAYS_LEAP
                                         : `CCT_DAYS_FEB;
      4'h4, 4'h6, 4'h9, 4'hb: days_in_month = `CCT_DAYS_SHORT;
      default: days_in_month = `CCT_DAYS_LONG;
    endcase
  end

  // Carry chain: each field wraps to its first value and carries on
  always_comb
  begin
    cal_inc = cal;
    if (cal.second != `CCT_SEC_MAX)
      cal_inc.second = cal.second + 6'h1;
    else
    begin
      cal_inc.second = 6'h0;
      if (cal.minute != `CCT_MIN_MAX)
        cal_inc.minute = cal.minute + 6'h1;
      else
      begin
        cal_inc.minute = 6'h0;
        if (cal.hour != `CCT_HOUR_MAX)
          cal_inc.hour = cal.hour + 5'h1;
        else
        begin
          cal_inc.hour = 5'h0;
          if (cal.day < days_in_month)
            cal_inc.day = cal.day + 5'h1;
          else
          begin
            cal_inc.day = `CCT_DAY_FIRST;
            if (cal.month < `CCT_MON_LAST)
              cal_inc.month = cal.month + 4'h1;
            else
            begin
              cal_inc.month = `CCT_MON_FIRST;
              cal_inc.year  = cal.year + 6'h1;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  wire [`CCT_CNT_W:0]    bin_sum = {1'b0, cnt_q} + 33'h1;
  wire                   match0  = (cnt_q == match_value_0_in);
  wire                   match1  = (cnt_q == match_value_1_in);
  // Calendar wraps from the last second of year offset 63
  wire                   cal_wrap = (cal_inc == cct_cal_s'(`CCT_CAL_RST))
                                    && (cal.year != 6'h0);
  wire                   wrap    = tick && (date_mode_bit_in ? cal_wrap
                                                             : bin_sum[32]);
  wire                   clr_hit = tick && clear_on_match_in && match0;
  logic [`CCT_CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (value_wr_in)
      cnt_d = value_wdata_in;
    else if (clr_hit)
      cnt_d = date_mode_bit_in ? `CCT_CAL_RST : `CCT_RST_VALUE;
    else if (tick && date_mode_bit_in)
      cnt_d = cal_inc;
    else if (tick)
      cnt_d = bin_sum[`CCT_CNT_W-1:0];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      cnt_q <= `CCT_RST_VALUE;
    else
      cnt_q <= cnt_d;
  end

  assign value_out = cnt_q;

  // ----------------------------------------------------------------
  // Status, mask and request lines
  // ----------------------------------------------------------------
  logic     sync_pend_q;
  logic     busy_q;
  logic     match0_q;
  logic     match1_q;
  cct_irq_t status_q;
  cct_irq_t mask_q;
  cct_irq_t events;
  cct_irq_t gated;

  // Match flags fire on entering the match, not every cycle it holds
  assign events[`CCT_IRQ_OVF]    = wrap | clr_hit;
  assign events[`CCT_IRQ_PER0]   = per0_ev;
  assign events[`CCT_IRQ_PER1]   = per1_ev;
  assign events[`CCT_IRQ_MATCH0] = match0 & ~match0_q;
  assign events[`CCT_IRQ_MATCH1] = match1 & ~match1_q;
  assign events[`CCT_IRQ_CLKRDY] = sync_pend_q & ~clock_sync_pending_in;
  assign events[`CCT_IRQ_READY]  = busy_q & ~busy_in;

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      sync_pend_q <= 1'b0;
      busy_q      <= 1'b0;
      match0_q    <= 1'b0;
      match1_q    <= 1'b0;
      status_q    <= 7'h00;
      mask_q      <= 7'h00;
    end
    else
    begin
      sync_pend_q <= clock_sync_pending_in;
      busy_q      <= busy_in;
      match0_q    <= match0;
      match1_q    <= match1;
      // A new event wins over a clear in the same cycle
      status_q    <= (status_q & ~status_clear_in) | events;
      mask_q      <= (mask_q | mask_set_in) & ~mask_clear_in;
    end
  end

  assign gated        = status_q & mask_q;
  assign status_out   = status_q;
  assign irq_mask_out = mask_q;
  // Plain levels so a sleeping core can be woken by any of them
  assign overflow_irq_out        = gated[`CCT_IRQ_OVF];
  assign periodic_irq_out        = gated[`CCT_IRQ_PER0]
                                 | gated[`CCT_IRQ_PER1];
  assign match_irq_out           = gated[`CCT_IRQ_MATCH0]
                                 | gated[`CCT_IRQ_MATCH1];
  assign clock_sync_done_irq_out = gated[`CCT_IRQ_CLKRDY];
  assign ready_irq_out           = gated[`CCT_IRQ_READY];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cal_sec_wrap;
    @(posedge ref_clk_in) disable iff (rst_in)
    (date_mode_bit_in && tick && !value_wr_in && !clr_hit
     && cal.second == `CCT_SEC_MAX) |=> (cal.second == 6'h0);
  endproperty
  a_cal_sec_wrap: assert property (p_cal_sec_wrap)
    else $error("seconds did not wrap to zero");

  property p_hour_range;
    @(posedge ref_clk_in) disable iff (rst_in)
    (date_mode_bit_in && tick && !value_wr_in && cal.hour <= `CCT_HOUR_MAX)
    |=> (cal.hour <= `CCT_HOUR_MAX);
  endproperty
  a_hour_range: assert property (p_hour_range)
    else $error("hour left 24-hour range");

  property p_feb_leap;
    @(posedge ref_clk_in) disable iff (rst_in)
    (date_mode_bit_in && tick && !value_wr_in && !clr_hit
     && cal.month == `CCT_MON_FEB && cal.day == `CCT_DAYS_FEB
     && cal.hour == `CCT_HOUR_MAX && cal.minute == `CCT_MIN_MAX
     && cal.second == `CCT_SEC_MAX)
    |=> (cal.day == (leap ? `CCT_DAYS_LEAP : `CCT_DAY_FIRST));
  endproperty
  a_feb_leap: assert property (p_feb_leap)
    else $error("leap day handling wrong");

  property p_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    value_wr_in |=> (value_out == $past(value_wdata_in));
  endproperty
  a_write: assert property (p_write)
    else $error("written value not loaded");
  property p_bin_count;
    @(posedge ref_clk_in) disable iff (rst_in)
    (!date_mode_bit_in && tick && !value_wr_in && !clr_hit)
    |=> (cnt_q == $past(cnt_q) + 32'h1);
  endproperty
  a_bin_count: assert property (p_bin_count)
    else $error("binary count did not advance");
  property p_ovf_wrap;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wrap || clr_hit) |=> status_q[`CCT_IRQ_OVF];
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap)
    else $error("overflow flag not set");
  property p_clkrdy;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(clock_sync_pending_in) |=> status_q[`CCT_IRQ_CLKRDY];
  endproperty
  a_clkrdy: assert property (p_clkrdy)
    else $error("clock ready flag missing");
  property p_ready;
    @(posedge ref_clk_in) disable iff (rst_in)
    $fell(busy_in) |=> status_q[`CCT_IRQ_READY];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag missing");
  property p_mask;
    @(posedge ref_clk_in) disable iff (rst_in)
    (mask_set_in[`CCT_IRQ_OVF] && !mask_clear_in[`CCT_IRQ_OVF])
    |=> irq_mask_out[`CCT_IRQ_OVF] ##0
        (overflow_irq_out == status_out[`CCT_IRQ_OVF]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask set not effective");
  property p_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    (ready_irq_out && !status_clear_in[`CCT_IRQ_READY]
     && !mask_clear_in[`CCT_IRQ_READY]) |=> ready_irq_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped without clear");

  property p_per;
    @(posedge ref_clk_in) disable iff (rst_in)
    per0_ev |=> status_q[`CCT_IRQ_PER0];
  endproperty
  a_per: assert property (p_per)
    else $error("periodic flag missing");

  property p_match;
    @(posedge ref_clk_in) disable iff (rst_in)
    (match1 && !match1_q) |=> status_q[`CCT_IRQ_MATCH1];
  endproperty
  a_match: assert property (p_match)
    else $error("match flag missing");
endmodule

/* File: test/cct_calendar_timer_unit_test.sv */
// Self-checking bench for the calendar timer unit
`include "cct_defs.svh"
module cct_calendar_timer_unit_test
  import cct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        ref_clk_in = 1'b0;
  logic        rst_in, run_in, date_mode_bit_in, clear_on_match_in;
  logic [4:0]  tick_sel_in, per0_sel_in, per1_sel_in;
  logic        value_wr_in, clock_sync_pending_in, busy_in;
  logic [31:0] value_wdata_in, match_value_0_in, match_value_1_in;
  cct_irq_t    mask_set_in, mask_clear_in, status_clear_in;
  logic [31:0] value_out;
  cct_irq_t    status_out, irq_mask_out;
  logic        overflow_irq_out, periodic_irq_out, match_irq_out;
  logic        clock_sync_done_irq_out, ready_irq_out;
  int          fails, samples_checked;

  cct_calendar_timer_unit u_dut (
    .ref_clk_in              (ref_clk_in),
    .rst_in                  (rst_in),
    .run_in                  (run_in),
    .date_mode_bit_in        (date_mode_bit_in),
    .clear_on_match_in       (clear_on_match_in),
    .tick_sel_in             (tick_sel_in),
    .per0_sel_in             (per0_sel_in),
    .per1_sel_in             (per1_sel_in),
    .value_wr_in             (value_wr_in),
    .value_wdata_in          (value_wdata_in),
    .match_value_0_in        (match_value_0_in),
    .match_value_1_in        (match_value_1_in),
    .clock_sync_pending_in   (clock_sync_pending_in),
    .busy_in                 (busy_in),
    .mask_set_in             (mask_set_in),
    .mask_clear_in           (mask_clear_in),
    .status_clear_in         (status_clear_in),
    .value_out               (value_out),
    .status_out              (status_out),
    .irq_mask_out            (irq_mask_out),
    .overflow_irq_out        (overflow_irq_out),
    .periodic_irq_out        (periodic_irq_out),
    .match_irq_out           (match_irq_out),
    .clock_sync_done_irq_out (clock_sync_done_irq_out),
    .ready_irq_out           (ready_irq_out)
  );

  always #2 ref_clk_in = ~ref_clk_in;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Inputs always move 1 ns after the edge
  task automatic step(int n = 1);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic check_val(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_irq(string nm, cct_irq_t e, cct_irq_t g);
    check_val(nm, {25'h0, e}, {25'h0, g});
  endtask
  task automatic check_bit(string nm, logic e, logic g);
    check_val(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic wrap_up();
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wait_stat(int b);
    int i;
    for (i = 0; i < 400 && status_out[b] !== 1'b1; i++)
      step();
    if (status_out[b] !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED status bit %0d expected 1 seen 0", b);
      wrap_up();
    end
  endtask
  task automatic load(logic [31:0] d);
    step();
    value_wr_in = 1'b1;
    value_wdata_in = d;
    step();
    value_wr_in = 1'b0;
    check_val("loaded value", d, value_out);
  endtask
  task automatic pulse(ref cct_irq_t s, input cct_irq_t m);
    s = m;
    step();
    s = 7'h00;
  endtask
  function automatic logic [31:0] cal(int y, int mo, int d, int h, int mi,
    int s);
    cct_cal_s c;
    c = '{year: 6'(y), month: 4'(mo), day: 5'(d), hour: 5'(h),
          minute: 6'(mi), second: 6'(s)};
    return c;
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_mask();
    pulse(mask_set_in, 7'h7f);
    check_irq("mask all set", 7'h7f, irq_mask_out);
    step();
    mask_set_in = 7'h01;
    pulse(mask_clear_in, 7'h01);
    mask_set_in = 7'h00;
    check_irq("mask clear wins", 7'h7e, irq_mask_out);
    step();
    pulse(mask_clear_in, 7'h7f);
    check_irq("mask all clear", 7'h00, irq_mask_out);
  endtask
  // Falling edges of the two sync levels, masked in and then out
  task automatic t_sync(logic en);
    if (en)
      pulse(mask_set_in, 7'h60);
    busy_in = 1'b1;
    clock_sync_pending_in = 1'b1;
    step(2);
    check_irq("no edge yet", 7'h00, status_out);
    busy_in = 1'b0;
    clock_sync_pending_in = 1'b0;
    wait_stat(`CCT_IRQ_READY);
    wait_stat(`CCT_IRQ_CLKRDY);
    step(5);
    check_bit("ready irq", en, ready_irq_out);
    check_bit("clkrdy irq", en, clock_sync_done_irq_out);
    pulse(status_clear_in, 7'h60);
    step();
    check_irq("status cleared", 7'h00, status_out);
    check_bit("ready irq off", 1'b0, ready_irq_out);
    pulse(mask_clear_in, 7'h60);
  endtask
  // One tick from a start value in the chosen mode
  task automatic t_step(logic m, logic [31:0] s, logic [31:0] e);
    int i;
    date_mode_bit_in = m;
    load(s);
    run_in = 1'b1;
    for (i = 0; i < 20 && value_out === s; i++)
      step();
    run_in = 1'b0;
    check_val("value after tick", e, value_out);
  endtask
  task automatic t_wrap(logic m, logic [31:0] s, logic [31:0] e);
    pulse(status_clear_in, 7'h7f);
    pulse(mask_set_in, 7'h01);
    t_step(m, s, e);
    wait_stat(`CCT_IRQ_OVF);
    check_bit("overflow irq", 1'b1, overflow_irq_out);
    pulse(mask_clear_in, 7'h01);
  endtask
  task automatic t_match(logic com);
    date_mode_bit_in = 1'b0;
    clear_on_match_in = com;
    pulse(status_clear_in, 7'h7f);
    pulse(mask_set_in, 7'h18);
    match_value_0_in = 32'h0000_0010;
    match_value_1_in = 32'h0000_0020;
    load(32'h0000_0008);
    run_in = 1'b1;
    wait_stat(`CCT_IRQ_MATCH0);
    check_bit("match irq", 1'b1, match_irq_out);
    check_bit("match1 early", 1'b0, status_out[`CCT_IRQ_MATCH1]);
    if (com)
    begin
      wait_stat(`CCT_IRQ_OVF);
      check_bit("cleared on match", 1'b1, value_out < 32'h10);
    end
    else
      wait_stat(`CCT_IRQ_MATCH1);
    run_in = 1'b0;
    clear_on_match_in = 1'b0;
    pulse(mask_clear_in, 7'h18);
  endtask
  // Calendar-layout match value, reached two seconds after the load
  task automatic t_cal_match();
    date_mode_bit_in = 1'b1;
    match_value_1_in = cal(7, 3, 15, 12, 30, 0);
    pulse(status_clear_in, 7'h7f);
    pulse(mask_set_in, 7'h10);
    load(cal(7, 3, 15, 12, 29, 58));
    check_bit("match1 before", 1'b0, status_out[`CCT_IRQ_MATCH1]);
    run_in = 1'b1;
    wait_stat(`CCT_IRQ_MATCH1);
    run_in = 1'b0;
    check_val("at match", cal(7, 3, 15, 12, 30, 0), value_out);
    check_bit("cal match irq", 1'b1, match_irq_out);
    pulse(mask_clear_in, 7'h10);
  endtask
  task automatic t_periodic(logic m);
    date_mode_bit_in = m;
    // A tap change can fake an edge, so let it settle before the clear
    per0_sel_in = 5'h02;
    per1_sel_in = 5'h03;
    step();
    pulse(status_clear_in, 7'h7f);
    pulse(mask_set_in, 7'h06);
    check_bit("per0 idle", 1'b0, status_out[`CCT_IRQ_PER0]);
    run_in = 1'b1;
    wait_stat(`CCT_IRQ_PER0);
    wait_stat(`CCT_IRQ_PER1);
    check_bit("periodic irq", 1'b1, periodic_irq_out);
    run_in = 1'b0;
    pulse(mask_clear_in, 7'h06);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_in, run_in, date_mode_bit_in, clear_on_match_in} = 4'h8;
    {tick_sel_in, per0_sel_in, per1_sel_in} = 15'h0;
    {value_wr_in, clock_sync_pending_in, busy_in} = 3'h0;
    value_wdata_in = 32'h0;
    match_value_0_in = 32'hffff_0000;
    match_value_1_in = 32'hffff_0000;
    {mask_set_in, mask_clear_in, status_clear_in} = 21'h0;
    fails = 0;
    samples_checked = 0;
    step(10);
    rst_in = 1'b0;
    check_val("reset value", `CCT_RST_VALUE, value_out);
    check_irq("reset status", 7'h00, status_out);
    check_irq("reset mask", 7'h00, irq_mask_out);
    t_mask();
    t_sync(1'b1);
    t_sync(1'b0);
    t_step(1'b0, 32'h0000_003b, 32'h0000_003c);
    t_step(1'b1, cal(0, 1, 1, 0, 59, 59), cal(0, 1, 1, 1, 0, 0));
    t_step(1'b1, cal(4, 2, 28, 23, 59, 59), cal(4, 2, 29, 0, 0, 0));
    t_step(1'b1, cal(5, 2, 28, 23, 59, 59), cal(5, 3, 1, 0, 0, 0));
    t_step(1'b1, cal(4, 2, 29, 23, 59, 59), cal(4, 3, 1, 0, 0, 0));
    t_step(1'b1, cal(5, 4, 30, 23, 59, 59), cal(5, 5, 1, 0, 0, 0));
    t_step(1'b1, cal(5, 1, 31, 23, 59, 59), cal(5, 2, 1, 0, 0, 0));
    t_step(1'b1, cal(5, 12, 31, 23, 59, 59), cal(6, 1, 1, 0, 0, 0));
    t_wrap(1'b0, 32'hffff_ffff, 32'h0000_0000);
    t_wrap(1'b1, cal(63, 12, 31, 23, 59, 59), `CCT_CAL_RST);
    t_cal_match();
    t_match(1'b0);
    t_match(1'b1);
    t_periodic(1'b0);
    t_periodic(1'b1);
    wrap_up();
  end
endmodule
